// >>> src/sadc_pkg.sv
package sadc_pkg;

  // ----------------------------------------------------------------------
  // Result word and queue
  // ----------------------------------------------------------------------
  localparam int RES_W      = 20;
  localparam int FIFO_DEPTH = 16;
  localparam int BIT_IDX_W  = 5;

  // ----------------------------------------------------------------------
  // Timing; the cycle counts are derived from the system clock period
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_CONV_MIN_NS = 1000;
  localparam int T_CONV_MAX_NS = 1500;
  localparam int CONV_MIN_CYC  = (T_CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_MAX_CYC  = T_CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int STEP_CYC      = CONV_MIN_CYC / RES_W;
  localparam int STEP_W        = 4;

  // ----------------------------------------------------------------------
  // Fixed values
  // ----------------------------------------------------------------------
  localparam logic [RES_W-1:0]     TRIAL_INIT = 20'h8_0000;
  localparam logic [RES_W-1:0]     CODE_MAX   = 20'h7_FFFF;
  localparam logic [RES_W-1:0]     CODE_MIN   = 20'h8_0000;
  localparam logic [STEP_W-1:0]    STEP_LAST  = STEP_W'(STEP_CYC - 1);
  localparam logic [BIT_IDX_W-1:0] BIT_TOP    = BIT_IDX_W'(RES_W - 1);
  localparam int                   SQZ_SHIFT  = 2;

  // Conversion control; the spare code 2'b10 is illegal.
  typedef enum logic [1:0] {
    SADC_OFF  = 2'b00,
    SADC_CONV = 2'b01,
    SADC_PUSH = 2'b11
  } sadc_state_t;

endpackage : sadc_pkg

// >>> src/sadc_top.sv
`timescale 1ns/100ps

// --------------------------------------------------------------------------
// Result queue
// --------------------------------------------------------------------------
module sadc_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16
) (
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic             clk_en_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem      [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : wrap_inc

  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];

  always_comb begin
    push        = clk_en_i && in_valid_i && in_ready_o;
    pop         = clk_en_i && out_valid_o && out_ready_i;
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_mem[wr_ptr] = in_data_i;
      next_wr_ptr      = wrap_inc(wr_ptr);
    end
    if (pop) begin
      next_rd_ptr = wrap_inc(rd_ptr);
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem    <= '{default: '0};
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      mem    <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

endmodule : sadc_fifo

// What this block does
// - A rising convert_strobe edge wakes the converter and starts a conversion.
// - Busy rises when a conversion starts and falls when it completes.
// - Cascade_select low: normal mode, shared pin is output_enable_n.
// - Cascade_select high: chain mode, shared pin is cascade_data_in.
// - Normal mode drives serial output while output_enable_n low, else released.
// - Enabled output shifts result or chain data, one bit per SCK rise, MSB first.
// - The result word is two's complement.
// - When busy falls with nothing held or queued, the result MSB is already on the serial output.
// - Chain mode captures cascade_data_in on each rising SCK edge.
// - Strap low rescales codes so 10% to 90% of input spans full scale.
// - Each finished conversion yields a 20-bit code ready for transfer.
// - The converter powers itself down between conversions.
module sadc_top
  import sadc_pkg::*;
(
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic             clk_en_i,
  input  wire logic             convert_strobe_i,
  input  wire logic             cascade_select_i,
  input  wire logic             enable_or_cascade_pin_i,
  input  wire logic             range_squeeze_strap_i,
  input  wire logic             sck_i,
  input  wire logic             comparator_i,
  output logic                  busy_o,
  output logic                  analog_enable_o,
  output logic      [RES_W-1:0] dac_code_o,
  output logic                  sdo_o,
  output logic                  sdo_oe_o
);

  // ------------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------------
  // Bit order: ack toggle, strap, enable, cascade select, strobe.
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic [4:0] next_pin_meta;
  logic [4:0] next_pin_sync;
  logic       strb_prev;
  logic       next_strb_prev;
  logic       ack_tog;
  logic       strobe_rise;
  logic       gain_squeeze;

  always_comb begin
    next_pin_meta  = pin_meta;
    next_pin_sync  = pin_sync;
    next_strb_prev = strb_prev;
    if (clk_en_i) begin
      next_pin_meta  = {ack_tog, range_squeeze_strap_i, enable_or_cascade_pin_i,
                        cascade_select_i, convert_strobe_i};
      next_pin_sync  = pin_meta;
      next_strb_prev = pin_sync[0];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta  <= '0;
      pin_sync  <= '0;
      strb_prev <= 1'b0;
    end else begin
      pin_meta  <= next_pin_meta;
      pin_sync  <= next_pin_sync;
      strb_prev <= next_strb_prev;
    end
  end

  assign strobe_rise  = pin_sync[0] && !strb_prev;
  assign gain_squeeze = !pin_sync[3];

  // ------------------------------------------------------------------------
  // Gain compression
  // ------------------------------------------------------------------------
  // Multiplies by 1.25 and saturates, so 80% of the input span fills the code.
  function automatic logic [RES_W-1:0] squeeze(input logic [RES_W-1:0] code);
    logic signed [RES_W+1:0] wide;
    wide = $signed({{2{code[RES_W-1]}}, code});
    wide = wide + (wide >>> SQZ_SHIFT);
    if (wide > $signed({2'b00, CODE_MAX})) begin
      squeeze = CODE_MAX;
    end else if (wide < $signed({2'b11, CODE_MIN})) begin
      squeeze = CODE_MIN;
    end else begin
      squeeze = wide[RES_W-1:0];
    end
  endfunction : squeeze

  // ------------------------------------------------------------------------
  // Conversion control
  // ------------------------------------------------------------------------
  sadc_state_t          state;
  sadc_state_t          next_state;
  logic [RES_W-1:0]     trial;
  logic [RES_W-1:0]     next_trial;
  logic [BIT_IDX_W-1:0] bit_idx;
  logic [BIT_IDX_W-1:0] next_bit_idx;
  logic [STEP_W-1:0]    step_cnt;
  logic [STEP_W-1:0]    next_step_cnt;
  logic [RES_W-1:0]     held_word;
  logic [RES_W-1:0]     next_held_word;
  logic                 load_tog;
  logic                 next_load_tog;
  logic                 next_busy;
  logic                 next_analog_en;
  logic                 next_sdo_oe;
  logic [RES_W-1:0]     result;
  logic                 drain_free;
  logic                 fifo_in_valid;
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  logic                 fifo_out_ready;
  logic [RES_W-1:0]     fifo_out_data;

  always_comb begin
    next_state     = state;
    next_trial     = trial;
    next_bit_idx   = bit_idx;
    next_step_cnt  = step_cnt;
    next_held_word = held_word;
    next_load_tog  = load_tog;
    fifo_in_valid  = 1'b0;
    fifo_out_ready = 1'b0;
    drain_free     = (load_tog == pin_sync[4]);
    result = {~trial[RES_W-1], trial[RES_W-2:0]};
    if (gain_squeeze) begin
      result = squeeze(result);
    end
    if (clk_en_i) begin
      unique case (state)
        SADC_OFF: begin
          if (strobe_rise) begin
            next_state    = SADC_CONV;
            next_trial    = TRIAL_INIT;
            next_bit_idx  = BIT_TOP;
            next_step_cnt = '0;
          end
        end
        SADC_CONV: begin
          if (step_cnt == STEP_LAST) begin
            next_step_cnt = '0;
            if (!comparator_i) begin
              next_trial[bit_idx] = 1'b0;
            end
            if (bit_idx == '0) begin
              next_state = SADC_PUSH;
            end else begin
              next_bit_idx                = bit_idx - 1'b1;
              next_trial[bit_idx - 1'b1] = 1'b1;
            end
          end else begin
            next_step_cnt = step_cnt + 1'b1;
          end
        end
        SADC_PUSH: begin
          // bypass puts the MSB out as busy falls
          if (drain_free && !fifo_out_valid) begin
            next_held_word = result;
            next_load_tog  = ~load_tog;
            next_state     = SADC_OFF;
          end else begin
            // unread results wait in the queue
            fifo_in_valid = 1'b1;
            if (fifo_in_ready) begin
              next_state = SADC_OFF;
            end
          end
        end
        default: begin
          next_state = SADC_OFF;
        end
      endcase
      // The queue also drains while a result waits to enter it, else a full queue deadlocks.
      if (fifo_out_valid && drain_free) begin
        fifo_out_ready = 1'b1;
        next_held_word = fifo_out_data;
        next_load_tog  = ~load_tog;
      end
    end
    next_busy      = (next_state != SADC_OFF);
    next_analog_en = (next_state == SADC_CONV);
    next_sdo_oe    = pin_sync[1] || !pin_sync[2];
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state           <= SADC_OFF;
      trial           <= '0;
      bit_idx         <= '0;
      step_cnt        <= '0;
      held_word       <= '0;
      load_tog        <= 1'b0;
      busy_o          <= 1'b0;
      analog_enable_o <= 1'b0;
      sdo_oe_o        <= 1'b0;
    end else if (clk_en_i) begin
      state           <= next_state;
      trial           <= next_trial;
      bit_idx         <= next_bit_idx;
      step_cnt        <= next_step_cnt;
      held_word       <= next_held_word;
      load_tog        <= next_load_tog;
      busy_o          <= next_busy;
      analog_enable_o <= next_analog_en;
      sdo_oe_o        <= next_sdo_oe;
    end
  end

  assign dac_code_o = trial;

  sadc_fifo #(
    .WIDTH (RES_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .clk_en_i    (clk_en_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (result),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  // ------------------------------------------------------------------------
  // Serial link, on the host's clock
  // ------------------------------------------------------------------------
  // The word is released only after its last bit has left, so held word and
  // load toggle stay quiet while SCK shifts it and are read without syncing.
  // Limitation: chain edges past the word may meet a queued word next.
  logic [RES_W-1:0]     shift;
  logic [RES_W-1:0]     next_shift;
  logic [BIT_IDX_W-1:0] bits_left;
  logic [BIT_IDX_W-1:0] next_bits_left;
  logic                 take_tog;
  logic                 next_take_tog;
  logic                 next_ack_tog;
  logic                 fresh;
  logic                 chain_bit;

  always_comb begin
    fresh          = load_tog ^ take_tog;
    // upstream data enters in chain mode
    chain_bit      = cascade_select_i && enable_or_cascade_pin_i;
    next_take_tog  = load_tog;
    next_ack_tog   = ack_tog;
    next_bits_left = bits_left;
    // MSB first, one bit per edge
    if (fresh) begin
      next_shift     = {held_word[RES_W-2:0], chain_bit};
      next_bits_left = BIT_TOP;
    end else begin
      next_shift = {shift[RES_W-2:0], chain_bit};
      if (bits_left != '0) begin
        next_bits_left = bits_left - 1'b1;
      end
      // last bit out frees the held word
      if (bits_left == BIT_IDX_W'(1)) begin
        next_ack_tog = take_tog;
      end
    end
  end

  always_ff @(posedge sck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift     <= '0;
      bits_left <= '0;
      take_tog  <= 1'b0;
      ack_tog   <= 1'b0;
    end else begin
      shift     <= next_shift;
      bits_left <= next_bits_left;
      take_tog  <= next_take_tog;
      ack_tog   <= next_ack_tog;
    end
  end

  assign sdo_o = fresh ? held_word[RES_W-1] : shift[RES_W-1];

  // ------------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------------
  logic [7:0] busy_cnt;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_cnt <= '0;
    end else if (clk_en_i) begin
      busy_cnt <= busy_o ? busy_cnt + 1'b1 : 8'h00;
    end
  end

  strobe_start_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    clk_en_i && state == SADC_OFF && strobe_rise |=> busy_o && analog_enable_o)
    else $error("Strobe did not start a conversion.");

  busy_track_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    $fell(busy_o) |-> state == SADC_OFF && $past(state) == SADC_PUSH)
    else $error("Busy fell outside conversion end.");

  conv_time_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    $fell(busy_o) && $past(state, 2) == SADC_CONV |->
      $past(busy_cnt) >= CONV_MIN_CYC && $past(busy_cnt) <= CONV_MAX_CYC)
    else $error("Conversion time out of range.");

  normal_oe_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    clk_en_i && !pin_sync[1] |=> sdo_oe_o == !$past(pin_sync[2]))
    else $error("Output enable does not follow the pin.");

  chain_oe_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    clk_en_i && pin_sync[1] |=> sdo_oe_o)
    else $error("Chain mode left the output undriven.");

  msb_ready_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    $fell(busy_o) && $past(drain_free) && !$past(fifo_in_valid) |->
      sdo_o == held_word[RES_W-1] && held_word == $past(result))
    else $error("Result MSB not presented at busy fall.");

  code_form_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    state == SADC_PUSH && !gain_squeeze |-> result[RES_W-1] == ~trial[RES_W-1])
    else $error("Result not in two's complement.");

  power_down_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    state == SADC_OFF && !$past(strobe_rise) |-> !analog_enable_o)
    else $error("Converter powered while idle.");

  shift_path_a: assert property (
    @(posedge sck_i) disable iff (!rst_n_i)
    !fresh |=> shift[RES_W-1:1] == $past(shift[RES_W-2:0]) &&
      shift[0] == $past(chain_bit))
    else $error("Serial shift path broken.");

  conv_done_c: cover property (@(posedge clock_i) disable iff (!rst_n_i) $fell(busy_o));
  queue_c:     cover property (@(posedge clock_i) disable iff (!rst_n_i) !fifo_in_ready);
  chain_c:     cover property (@(posedge sck_i) disable iff (!rst_n_i) chain_bit);

endmodule : sadc_top

// >>> sim/sadc_host_model.sv
`timescale 1ns/100ps

// ------------------------------------------------------------------
// Host controller that owns the strobe, the serial clock and the pin
// ------------------------------------------------------------------
module sadc_host_model (
  input  wire logic clock_i,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i,
  output logic      strobe_o,
  output logic      sck_o,
  output logic      pin_o
);
  initial begin
    strobe_o = 1'b0;
    sck_o = 1'b0;
    pin_o = 1'b0;
  end

  task automatic strobe(input logic lvl);
    @(posedge clock_i);
    strobe_o <= lvl;
  endtask : strobe

  task automatic set_pin(input logic lvl);
    @(posedge clock_i);
    pin_o <= lvl;
  endtask : set_pin

  // slow idle clock.
  // The clock stands low between frames; its phase is unrelated to clock_i.
  task automatic shift(input int n, input logic [31:0] cin, output logic [31:0] q);
    q = '0;
    #37;
    for (int i = n - 1; i >= 0; i--) begin
      pin_o = cin[i];
      #62.5;
      q[i] = sdo_oe_i ? sdo_i : 1'bx;
      sck_o = 1'b1;
      #62.5;
      sck_o = 1'b0;
    end
  endtask : shift
endmodule : sadc_host_model

// >>> sim/tb_top.sv
`timescale 1ns/100ps

module tb_top;
  import sadc_pkg::*;
  logic             clock_i = 1'b0;
  logic             rst_n_i = 1'b0;
  logic             cascade = 1'b0;
  logic             strap = 1'b1;
  logic             clk_en = 1'b1;
  logic             strobe, sck, pin, busy, aen, sdo, oe, cmp;
  logic [RES_W-1:0] dac, ain;
  int               err_total = 0;
  int               n_checks = 0;

  always #5 clock_i = ~clock_i;
  // A keep decision whenever the trial code does not exceed the input.
  assign cmp = (dac <= ain);

  sadc_top uut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en),
    .convert_strobe_i(strobe), .cascade_select_i(cascade),
    .enable_or_cascade_pin_i(pin), .range_squeeze_strap_i(strap),
    .sck_i(sck), .comparator_i(cmp), .busy_o(busy),
    .analog_enable_o(aen), .dac_code_o(dac), .sdo_o(sdo), .sdo_oe_o(oe)
  );

  sadc_host_model host (
    .clock_i(clock_i), .sdo_i(sdo), .sdo_oe_i(oe),
    .strobe_o(strobe), .sck_o(sck), .pin_o(pin)
  );

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick

  function automatic logic [RES_W-1:0] exp_code(input logic [RES_W-1:0] v);
    logic signed [RES_W+1:0] c;
    c = $signed({{3{~v[RES_W-1]}}, v[RES_W-2:0]});
    if (strap === 1'b0) c = c + (c >>> 2);
    if (c[RES_W+1:RES_W-1] != {3{c[RES_W+1]}}) return c[RES_W+1] ? CODE_MIN : CODE_MAX;
    return c[RES_W-1:0];
  endfunction : exp_code

  // Mode 0: queue full, 1: idle link, 2: result queued behind others.
  task automatic convert(input logic [RES_W-1:0] v, input int mode);
    int n;
    ain <= v;
    host.strobe(1'b1);
    n = 0;
    do begin tick(1); n++; end while (busy !== 1'b1 && n < 10);
    chk("busy rise", 1, busy);
    chk("analog on", 1, aen);
    host.strobe(1'b0);
    n++;
    while (busy === 1'b1 && n < 200) begin tick(1); n++; end
    if (mode == 0) begin
      chk("stalled busy", 1, busy);
    end else begin
      chk("conv time", 1, n >= CONV_MIN_CYC && n <= CONV_MAX_CYC);
      chk("analog off", 0, aen);
    end
    if (mode == 1) chk("first bit", exp_code(v) >> (RES_W - 1), sdo);
    tick(100);
  endtask : convert

  task automatic read_word(input logic [RES_W-1:0] v, input logic chain);
    logic [31:0] q;
    if (chain) begin
      host.shift(24, 32'h00B0_0000, q);
      chk("chain word", {exp_code(v), 4'hB}, q[23:0]);
    end else begin
      host.shift(RES_W, 32'h0000_0000, q);
      chk("word", exp_code(v), q[RES_W-1:0]);
    end
  endtask : read_word

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_codes();
    logic [RES_W-1:0] v [6] = '{20'h0_0000, 20'hF_FFFF, 20'h8_0000,
                                20'h7_FFFF, 20'h1_2345, 20'hA_5A5A};
    foreach (v[i]) begin
      convert(v[i], 1);
      read_word(v[i], 1'b0);
    end
  endtask : t_codes

  task automatic t_squeeze();
    logic [RES_W-1:0] v [4] = '{20'h0_0000, 20'hF_FFFF, 20'h9_0000, 20'h7_0000};
    strap <= 1'b0;
    tick(5);
    foreach (v[i]) begin
      convert(v[i], 1);
      read_word(v[i], 1'b0);
    end
    strap <= 1'b1;
    tick(5);
  endtask : t_squeeze

  task automatic t_oe();
    host.set_pin(1'b1);
    tick(5);
    chk("oe off", 0, oe);
    host.set_pin(1'b0);
    tick(5);
    chk("oe on", 1, oe);
  endtask : t_oe

  // A second strobe inside a conversion must neither restart nor stretch it.
  task automatic t_ignore();
    fork
      convert(20'h6_1234, 1);
      begin
        tick(40);
        host.strobe(1'b1);
        tick(5);
        host.strobe(1'b0);
      end
    join
    tick(30);
    chk("busy idle", 0, busy);
    read_word(20'h6_1234, 1'b0);
  endtask : t_ignore

  task automatic t_chain();
    cascade <= 1'b1;
    host.set_pin(1'b1);
    tick(5);
    chk("chain oe", 1, oe);
    convert(20'h3_C3C3, 1);
    read_word(20'h3_C3C3, 1'b1);
    cascade <= 1'b0;
    host.set_pin(1'b0);
    tick(5);
  endtask : t_chain

  // Held word plus 16 queued results fill the path; the next one stalls.
  task automatic t_fifo();
    for (int i = 0; i < 18; i++) begin
      convert(RES_W'(i * 32'h0000_F0F1), i == 0 ? 1 : (i == 17 ? 0 : 2));
    end
    for (int i = 0; i < 18; i++) begin
      read_word(RES_W'(i * 32'h0000_F0F1), 1'b0);
    end
  endtask : t_fifo

  // A low clock enable must hold a conversion exactly where it stands.
  task automatic t_freeze();
    logic [RES_W-1:0] d;
    ain <= 20'h2_4680;
    host.strobe(1'b1);
    tick(20);
    host.strobe(1'b0);
    clk_en <= 1'b0;
    tick(1);
    d = dac;
    tick(50);
    chk("frozen code", d, dac);
    chk("frozen busy", 1, busy);
    @(posedge clock_i);
    clk_en <= 1'b1;
    tick(120);
    chk("busy after freeze", 0, busy);
    chk("bit after freeze", exp_code(20'h2_4680) >> (RES_W - 1), sdo);
    read_word(20'h2_4680, 1'b0);
  endtask : t_freeze

  // A reset with the block idle clears the outputs and leaves the block ready again.
  task automatic t_reset();
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    tick(2);
    chk("reset busy", 0, busy);
    chk("reset oe", 0, oe);
    chk("reset code", 0, dac);
    @(posedge clock_i);
    rst_n_i <= 1'b1;
    tick(5);
    chk("oe after reset", 1, oe);
    convert(20'h5_5555, 1);
    read_word(20'h5_5555, 1'b0);
  endtask : t_reset

  // ------------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  initial begin
    ain = '0;
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    tick(5);
    t_codes();
    t_squeeze();
    t_oe();
    t_ignore();
    t_chain();
    t_freeze();
    t_fifo();
    t_reset();
    test_done();
  end

  // About 30 conversions, gaps and frames need near 150 us; allow over twice that.
  initial begin
    #400000;
    err_total++;
    $display("ERROR watchdog expected finish seen hang");
    test_done();
  end
endmodule : tb_top
